// ==== hdl/power_mgmt_pkg.sv ====
// Constants, types and helpers shared by the power management block.
package power_mgmt_pkg;

   // ************************************************************
   // Register addresses
   // ************************************************************
   localparam logic [7:0] ADDR_IRQ_PRIO_TWO = 8'hA9;
   localparam logic [7:0] ADDR_EVENT_ENABLE = 8'hEC;
   localparam logic [7:0] ADDR_EVENT_FLAGS = 8'hF8;
   localparam logic [7:0] ADDR_PERIPHERAL_CONFIG_REG_CFG = 8'hF4;
   localparam logic [7:0] ADDR_SWITCH_CFG = 8'hF5;
   localparam logic [7:0] ADDR_DELTA = 8'hF3;
   localparam logic [7:0] ADDR_START_MEAS = 8'hD8;
   localparam logic [7:0] ADDR_BAT_THRESH = 8'hFA;
   localparam logic [7:0] ADDR_BAT_RESULT = 8'hDF;
   localparam logic [7:0] ADDR_DCIN_RESULT = 8'hEF;
   localparam logic [7:0] ADDR_PIN_CFG = 8'hFF;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int BIT_MASTER_EN = 1;
   localparam int BIT_SOURCE = 6;
   localparam int BIT_SWITCH_OFF = 1;
   localparam int PIN_FN_LSB = 2;
   localparam int BIT_DCIN_LOW = 0;
   localparam int BIT_SWITCHOVER = 1;
   localparam int BIT_BATTERY = 2;
   localparam int BIT_DCIN_ADC = 3;
   localparam int BIT_SAG = 5;
   localparam int BIT_RESTORE = 7;
   localparam logic [7:0] FLAG_MASK = 8'hAF;
   localparam logic [1:0] CAUSE_DCIN = 2'h1;
   localparam logic [1:0] PIN_FN_BATTERY = 2'h1;

   // ************************************************************
   // Reset values
   // ************************************************************
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [7:0] RST_THRESH = 8'h00;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned DCIN_SWITCH_MS = 30;
   localparam int unsigned RESTORE_MS = 130;
   localparam int unsigned STROBE_MS = 100;
   localparam int unsigned DCIN_SWITCH_CYC = DCIN_SWITCH_MS * (CLK_HZ / 1000);
   localparam int unsigned RESTORE_CYC = RESTORE_MS * (CLK_HZ / 1000);
   localparam int unsigned STROBE_CYC = STROBE_MS * (CLK_HZ / 1000);

   typedef enum logic [1:0] {
      ON_MAIN = 2'b01,
      ON_BATTERY = 2'b10
   } supply_state_t;

   function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                           input logic [7:0] b);
      abs_diff = (a > b) ? 8'(a - b) : 8'(b - a);
   endfunction

endpackage

// ==== hdl/delay_timer.sv ====
// Qualification timer: expires once its run input has held long enough.
`timescale 1ns/1ps
module delay_timer #(
   parameter int unsigned CYCLES = 1
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic run,
   output logic expired
);
   localparam int W = $clog2(CYCLES + 1);
   logic [W-1:0] count_reg;

   // Any drop of run restarts the wait, so a glitch never shortens it.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= '0;
         expired <= 1'b0;
      end else if (!run) begin
         count_reg <= '0;
         expired <= 1'b0;
      end else if (count_reg >= W'(CYCLES - 1)) begin
         expired <= 1'b1;
      end else begin
         count_reg <= count_reg + 1'b1;
      end
   end
endmodule // delay_timer

// ==== hdl/sag_counter.sv ====
// Counts consecutive line cycles below the sag level.
`timescale 1ns/1ps
module sag_counter (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic line_cycle,
   input wire logic line_below_sag,
   input wire logic [7:0] sag_cycle_count_setting,
   output logic sag_hit
);
   logic [7:0] count_reg;
   logic [7:0] target;

   // A setting of zero is treated as one cycle.
   assign target = (sag_cycle_count_setting == 8'h00) ? 8'h01 :
                   sag_cycle_count_setting;

   // One pulse per sag; the count stops until the line recovers.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 8'h00;
         sag_hit <= 1'b0;
      end else begin
         sag_hit <= 1'b0;
         if (!line_below_sag) begin
            count_reg <= 8'h00;
         end else if (line_cycle && count_reg < target) begin
            count_reg <= count_reg + 8'h01;
            sag_hit <= (count_reg + 8'h01 == target);
         end
      end
   end
endmodule // sag_counter

// ==== hdl/power_mgmt.sv ====
// Supply switchover control and shared power event interrupt.
`timescale 1ns/1ps

module power_mgmt
   import power_mgmt_pkg::*;
#(
   parameter int unsigned SWITCH_CYCLES = DCIN_SWITCH_CYC,
   parameter int unsigned RESTORE_CYCLES = RESTORE_CYC,
   parameter int unsigned STROBE_CYCLES = STROBE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic vdd_ok,
   input wire logic dc_supervisory_input_ok,
   input wire logic battery_control_pin,
   input wire logic dcin_adc_valid,
   input wire logic [7:0] dcin_adc_data,
   input wire logic bat_adc_valid,
   input wire logic [7:0] bat_adc_data,
   input wire logic line_cycle,
   input wire logic line_below_sag,
   input wire logic [7:0] sag_cycle_count_setting,
   output logic internal_supply_rail,
   output logic dcin_conv_start,
   output logic power_irq
);

   // ************************************************************
   // Registers and state
   // ************************************************************
   logic [7:0] interrupt_enable_priority_two_reg;
   logic [7:0] power_event_enable_reg;
   logic [7:0] power_event_flags_reg;
   logic [7:0] power_event_flags_next;
   logic [7:0] switchover_config_reg;
   logic [7:0] temp_supply_delta_reg;
   logic [7:0] battery_threshold_reg;
   logic [7:0] battery_result_reg;
   logic [7:0] dcin_result_reg;
   logic [7:0] pin_config_reg;
   logic [7:0] rd_value;
   supply_state_t state_reg;
   supply_state_t state_next;
   logic pin_prev_reg;
   logic dcin_low_prev_reg;
   logic bat_low_prev_reg;
   logic sw_meas_pending_reg;
   logic [$clog2(STROBE_CYCLES + 1)-1:0] strobe_count_reg;
   logic strobe;

   // ************************************************************
   // Decode of configuration
   // ************************************************************
   logic [1:0] switchover_cause_select;
   logic [1:0] ext_pin_function_select;
   logic switch_disabled;
   logic dcin_cause;
   logic pin_cause;
   logic power_irq_master_enable;
   logic pin_fall;
   logic dcin_low;
   logic bat_low;
   logic restore_cond;
   logic dcin_expired;
   logic restore_expired;
   logic sag_hit;
   logic wr_flags;
   logic wr_start;

   assign switchover_cause_select = switchover_config_reg[1:0];
   assign ext_pin_function_select = pin_config_reg[PIN_FN_LSB +: 2];
   assign switch_disabled = switchover_config_reg[BIT_SWITCH_OFF];
   assign dcin_cause = (switchover_cause_select == CAUSE_DCIN);
   assign pin_cause = (ext_pin_function_select == PIN_FN_BATTERY);
   assign power_irq_master_enable =
      interrupt_enable_priority_two_reg[BIT_MASTER_EN];
   assign pin_fall = pin_prev_reg && !battery_control_pin;
   assign dcin_low = !dc_supervisory_input_ok;
   assign bat_low = battery_result_reg < battery_threshold_reg;
   assign wr_flags = sfr_wr && (sfr_addr == ADDR_EVENT_FLAGS);
   assign wr_start = sfr_wr && (sfr_addr == ADDR_START_MEAS);

   // All enabled causes must be false.
   // Main ok, plus input ok when selected.
   // Pin must be high when enabled.
   assign restore_cond = vdd_ok &&
                         (!dcin_cause || dc_supervisory_input_ok) &&
                         (!pin_cause || battery_control_pin);

   // ************************************************************
   // Qualification timers
   // ************************************************************
   // Low input held before switchover.
   delay_timer #(
      .CYCLES(SWITCH_CYCLES)
   ) u_switch_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(state_reg == ON_MAIN && dcin_cause && dcin_low),
      .expired(dcin_expired)
   );

   delay_timer #(
      .CYCLES(RESTORE_CYCLES)
   ) u_restore_timer (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .run(state_reg == ON_BATTERY && restore_cond),
      .expired(restore_expired)
   );

   sag_counter u_sag (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .line_cycle(line_cycle),
      .line_below_sag(line_below_sag),
      .sag_cycle_count_setting(sag_cycle_count_setting),
      .sag_hit(sag_hit)
   );

   // ************************************************************
   // Supply source state machine
   // ************************************************************
   // A main supply drop acts on the next edge; it is not timed.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ON_MAIN: begin
            if (!switch_disabled &&
                (!vdd_ok || dcin_expired || (pin_cause && pin_fall))) begin
               state_next = ON_BATTERY;
            end
         end
         ON_BATTERY: begin
            if (switch_disabled || restore_expired) begin
               state_next = ON_MAIN;
            end
         end
         default: begin
            state_next = ON_MAIN;
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ON_MAIN;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         internal_supply_rail <= 1'b1;
      end else begin
         internal_supply_rail <= (state_next == ON_MAIN);
      end
   end

   // ************************************************************
   // Edge history
   // ************************************************************
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_prev_reg <= 1'b1;
         dcin_low_prev_reg <= 1'b0;
         bat_low_prev_reg <= 1'b0;
      end else begin
         pin_prev_reg <= battery_control_pin;
         dcin_low_prev_reg <= dcin_low;
         bat_low_prev_reg <= bat_low;
      end
   end

   // ************************************************************
   // Measurement scheduling
   // ************************************************************
   // Background conversion strobe.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         strobe_count_reg <= '0;
      end else if (strobe) begin
         strobe_count_reg <= '0;
      end else begin
         strobe_count_reg <= strobe_count_reg + 1'b1;
      end
   end

   assign strobe = (strobe_count_reg ==
                    ($clog2(STROBE_CYCLES + 1))'(STROBE_CYCLES - 1));

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dcin_conv_start <= 1'b0;
      end else begin
         dcin_conv_start <= strobe || wr_start;
      end
   end

   // A software request always reports its result, even without a change.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_meas_pending_reg <= 1'b0;
      end else if (wr_start) begin
         sw_meas_pending_reg <= 1'b1;
      end else if (dcin_adc_valid) begin
         sw_meas_pending_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dcin_result_reg <= RST_REG;
      end else if (dcin_adc_valid) begin
         dcin_result_reg <= dcin_adc_data;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         battery_result_reg <= RST_REG;
      end else if (bat_adc_valid) begin
         battery_result_reg <= bat_adc_data;
      end
   end

   // ************************************************************
   // Event flags
   // ************************************************************
   always_comb begin
      power_event_flags_next = power_event_flags_reg;
      if (wr_flags) begin
         power_event_flags_next = power_event_flags_reg & sfr_wdata;
      end
      // Sets follow clears, so sets win.
      if (dcin_low && !dcin_low_prev_reg) begin
         power_event_flags_next[BIT_DCIN_LOW] = 1'b1;
      end
      if (state_reg == ON_MAIN && state_next == ON_BATTERY) begin
         power_event_flags_next[BIT_SWITCHOVER] = 1'b1;
      end
      if (state_reg == ON_BATTERY && state_next == ON_MAIN) begin
         power_event_flags_next[BIT_RESTORE] = 1'b1;
      end
      // New result or fall below threshold.
      if (bat_adc_valid || (bat_low && !bat_low_prev_reg)) begin
         power_event_flags_next[BIT_BATTERY] = 1'b1;
      end
      if (dcin_adc_valid &&
          (sw_meas_pending_reg ||
           abs_diff(dcin_adc_data, dcin_result_reg) >
           temp_supply_delta_reg)) begin
         power_event_flags_next[BIT_DCIN_ADC] = 1'b1;
      end
      if (sag_hit) begin
         power_event_flags_next[BIT_SAG] = 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_event_flags_reg <= RST_REG;
      end else begin
         power_event_flags_reg <= power_event_flags_next & FLAG_MASK;
      end
   end

   // ************************************************************
   // Interrupt output
   // ************************************************************
   // Driven from the next flag value so a set reaches the pin at once.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_irq <= 1'b0;
      end else begin
         // Nothing passes while master is off.
         power_irq <= power_irq_master_enable &&
                      |(power_event_flags_next & power_event_enable_reg &
                        FLAG_MASK);
      end
   end

   // ************************************************************
   // Register writes
   // ************************************************************
   // Master enable clear at reset.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         interrupt_enable_priority_two_reg <= RST_REG;
      end else if (sfr_wr && sfr_addr == ADDR_IRQ_PRIO_TWO) begin
         interrupt_enable_priority_two_reg <= sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         power_event_enable_reg <= RST_REG;
      end else if (sfr_wr && sfr_addr == ADDR_EVENT_ENABLE) begin
         power_event_enable_reg <= sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         switchover_config_reg <= RST_REG;
         temp_supply_delta_reg <= RST_THRESH;
         battery_threshold_reg <= RST_THRESH;
         pin_config_reg <= RST_REG;
      end else if (sfr_wr) begin
         if (sfr_addr == ADDR_SWITCH_CFG) begin
            switchover_config_reg <= sfr_wdata;
         end else if (sfr_addr == ADDR_DELTA) begin
            temp_supply_delta_reg <= sfr_wdata;
         end else if (sfr_addr == ADDR_BAT_THRESH) begin
            battery_threshold_reg <= sfr_wdata;
         end else if (sfr_addr == ADDR_PIN_CFG) begin
            pin_config_reg <= sfr_wdata;
         end
      end
   end

   // ************************************************************
   // Register reads
   // ************************************************************
   always_comb begin
      rd_value = 8'h00;
      if (sfr_addr == ADDR_IRQ_PRIO_TWO) begin
         rd_value = interrupt_enable_priority_two_reg;
      end else if (sfr_addr == ADDR_EVENT_ENABLE) begin
         rd_value = power_event_enable_reg;
      end else if (sfr_addr == ADDR_EVENT_FLAGS) begin
         rd_value = power_event_flags_reg;
      end else if (sfr_addr == ADDR_PERIPHERAL_CONFIG_REG_CFG) begin
         rd_value[BIT_SOURCE] = internal_supply_rail;
      end else if (sfr_addr == ADDR_SWITCH_CFG) begin
         rd_value = switchover_config_reg;
      end else if (sfr_addr == ADDR_DELTA) begin
         rd_value = temp_supply_delta_reg;
      end else if (sfr_addr == ADDR_BAT_THRESH) begin
         rd_value = battery_threshold_reg;
      end else if (sfr_addr == ADDR_BAT_RESULT) begin
         rd_value = battery_result_reg;
      end else if (sfr_addr == ADDR_DCIN_RESULT) begin
         rd_value = dcin_result_reg;
      end else if (sfr_addr == ADDR_PIN_CFG) begin
         rd_value = pin_config_reg;
      end
   end

   // Read data is held between reads so the core may sample it late.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         sfr_rdata <= rd_value;
      end
   end

endmodule // power_mgmt

// ==== tb/power_mgmt_sva.sv ====
// Port assertions for the power management block.
`timescale 1ns/1ps
module power_mgmt_sva
   import power_mgmt_pkg::*;
#(
   parameter int unsigned RESTORE_CYCLES = RESTORE_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic vdd_ok,
   input wire logic battery_control_pin,
   input wire logic internal_supply_rail,
   input wire logic dcin_conv_start,
   input wire logic power_irq
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   logic master_reg;
   logic off_reg;
   logic pin_reg;
   logic [7:0] en_reg;
   int unsigned ok_reg;
   // Shadow copies of the control bits, updated at the same edge as the block.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_reg <= 1'b0;
         off_reg <= 1'b0;
         pin_reg <= 1'b0;
         en_reg <= 8'h00;
      end else if (sfr_wr) begin
         if (sfr_addr == ADDR_IRQ_PRIO_TWO)
            master_reg <= sfr_wdata[BIT_MASTER_EN];
         if (sfr_addr == ADDR_SWITCH_CFG)
            off_reg <= sfr_wdata[BIT_SWITCH_OFF];
         if (sfr_addr == ADDR_PIN_CFG)
            pin_reg <= (sfr_wdata[PIN_FN_LSB +: 2] == PIN_FN_BATTERY);
         if (sfr_addr == ADDR_EVENT_ENABLE)
            en_reg <= sfr_wdata;
      end
   end
   // Counts consecutive cycles of a good main supply; saturates just past
   // the restore wait, so it stays bounded whatever the wait is set to.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) ok_reg <= 0;
      else if (!vdd_ok) ok_reg <= 0;
      else if (ok_reg <= RESTORE_CYCLES) ok_reg <= ok_reg + 1;
   end
   sequence s_to_battery;
      ##1 !internal_supply_rail;
   endsequence
   a_irq_off_reset: assert property (
      !master_reg && !$past(master_reg) |-> !power_irq)
      else $error("interrupt raised without master enable");
   a_irq_needs_enable: assert property (
      power_irq |-> (en_reg | $past(en_reg)) != 8'h00)
      else $error("interrupt raised with all events disabled");
   a_main_loss_switch: assert property (
      !vdd_ok && internal_supply_rail && !off_reg |-> s_to_battery)
      else $error("no switch to battery on main supply loss");
   a_pin_edge_switch: assert property (
      $fell(battery_control_pin) && pin_reg && internal_supply_rail &&
      !off_reg |-> s_to_battery)
      else $error("no switch to battery on pin falling edge");
   a_disabled_stays_main: assert property (
      off_reg && $past(off_reg) |-> internal_supply_rail)
      else $error("rail left main supply while switchover disabled");
   a_restore_after_wait: assert property (
      $rose(internal_supply_rail) && !off_reg |-> ok_reg > RESTORE_CYCLES)
      else $error("rail restored before qualification time");
   a_start_meas_pulse: assert property (
      sfr_wr && sfr_addr == ADDR_START_MEAS |-> ##[1:2] dcin_conv_start)
      else $error("no conversion start after start write");
   a_source_status_read: assert property (
      sfr_rd && sfr_addr == ADDR_PERIPHERAL_CONFIG_REG_CFG |=>
      sfr_rdata == {1'b0, $past(internal_supply_rail), 6'b0})
      else $error("source status read wrong");
   // The interrupt register sampled the enables at the same edge as the rail fell.
   a_switch_irq_raise: assert property (
      $fell(internal_supply_rail) && $past(master_reg) &&
      $past(en_reg[BIT_SWITCHOVER]) |-> power_irq)
      else $error("no interrupt on enabled switchover");
endmodule // power_mgmt_sva

bind power_mgmt power_mgmt_sva #(.RESTORE_CYCLES(RESTORE_CYCLES))
   i_power_mgmt_sva (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
   .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata), .vdd_ok(vdd_ok),
   .battery_control_pin(battery_control_pin),
   .internal_supply_rail(internal_supply_rail),
   .dcin_conv_start(dcin_conv_start), .power_irq(power_irq));

// ==== tb/core_model.sv ====
// Core side model: byte accesses to the special function registers.
`timescale 1ns/1ps
module core_model (
   input wire logic sys_clk,
   input wire logic [7:0] sfr_rdata,
   output logic [7:0] sfr_addr,
   output logic [7:0] sfr_wdata,
   output logic sfr_wr,
   output logic sfr_rd
);
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge sys_clk);
      sfr_wr = 1'b0;
      // Idle lines are scrambled so a stale value is never mistaken for data.
      sfr_addr = ~a;
      sfr_wdata = ~d;
      @(negedge sys_clk);
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge sys_clk);
      sfr_rd = 1'b0;
      sfr_addr = ~a;
      d = sfr_rdata;
      @(negedge sys_clk);
   endtask
endmodule // core_model

// ==== tb/power_mgmt_tb.sv ====
// Self-checking testbench for the power management block.
`timescale 1ns/1ps
`define CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin \
   n_mismatch++; $display("mismatch %s expected %h seen %h", nm, ex, sn); \
   end end
module power_mgmt_tb;
   import power_mgmt_pkg::*;
   localparam int SW = 5;
   localparam int RS = 8;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
   logic sfr_wr, sfr_rd, internal_supply_rail, dcin_conv_start, power_irq;
   logic vdd_ok = 1'b1, dc_ok = 1'b1, pin = 1'b1, dv = 1'b0, bv = 1'b0;
   logic lc = 1'b0, lbs = 1'b0;
   logic [7:0] dd = 8'h00, bd = 8'h00;
   int n_mismatch = 0, checked = 0, cyc = 0;
   int n_start = 0, s0 = 0;
   core_model i_core_model (.sys_clk(sys_clk), .sfr_rdata(sfr_rdata),
      .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd));
   // Long timers shortened so a full run stays under two hundred cycles.
   power_mgmt #(.SWITCH_CYCLES(SW), .RESTORE_CYCLES(RS), .STROBE_CYCLES(20))
      i_power_mgmt (.sys_clk(sys_clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata), .vdd_ok(vdd_ok), .dc_supervisory_input_ok(dc_ok),
      .battery_control_pin(pin), .dcin_adc_valid(dv), .dcin_adc_data(dd),
      .bat_adc_valid(bv), .bat_adc_data(bd), .line_cycle(lc),
      .line_below_sag(lbs), .sag_cycle_count_setting(8'h03),
      .internal_supply_rail(internal_supply_rail),
      .dcin_conv_start(dcin_conv_start), .power_irq(power_irq));
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic waitc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_core_model.wr_reg(a, d);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] ex,
                        input string nm);
      i_core_model.rd_reg(a, rd);
      `CHK(nm, ex, rd)
   endtask
   task automatic pulse_line();
      lc = 1'b1;
      waitc(1);
      lc = 1'b0;
      waitc(1);
   endtask
   // A hang counts as a failure; the whole sequence needs well under 1000.
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // Conversion start pulses seen at the port.
   always @(posedge sys_clk) begin
      if (dcin_conv_start === 1'b1) begin
         n_start++;
      end
   end
   initial begin
      waitc(6);
      rst_n = 1'b1;
      waitc(1);
      rdchk(ADDR_IRQ_PRIO_TWO, RST_REG, "prio");
      rdchk(ADDR_EVENT_ENABLE, RST_REG, "enable");
      rdchk(ADDR_EVENT_FLAGS, 8'h00, "flags");
      rdchk(ADDR_PERIPHERAL_CONFIG_REG_CFG, 8'h40, "status_main");
      rdchk(8'h00, 8'h00, "unmapped");
      vdd_ok = 1'b0;
      waitc(2);
      rdchk(ADDR_EVENT_FLAGS, 8'h02, "flag_switch");
      `CHK("irq_masked", 1'b0, power_irq)
      rdchk(ADDR_PERIPHERAL_CONFIG_REG_CFG, 8'h00, "status_bat");
      vdd_ok = 1'b1;
      waitc(RS - 2);
      `CHK("restore_early", 1'b0, internal_supply_rail)
      waitc(6);
      rdchk(ADDR_EVENT_FLAGS, 8'h82, "flag_restore");
      wr(ADDR_EVENT_FLAGS, 8'h00);
      rdchk(ADDR_EVENT_FLAGS, 8'h00, "cleared");
      wr(ADDR_EVENT_ENABLE, FLAG_MASK);
      wr(ADDR_IRQ_PRIO_TWO, 8'h02);
      vdd_ok = 1'b0;
      waitc(2);
      `CHK("irq_switch", 1'b1, power_irq)
      wr(ADDR_EVENT_FLAGS, 8'hFD);
      `CHK("irq_ack", 1'b0, power_irq)
      wr(ADDR_IRQ_PRIO_TWO, 8'h00);
      vdd_ok = 1'b1;
      waitc(RS + 4);
      `CHK("irq_master_off", 1'b0, power_irq)
      wr(ADDR_IRQ_PRIO_TWO, 8'h02);
      `CHK("irq_restore", 1'b1, power_irq)
      wr(ADDR_EVENT_FLAGS, 8'h00);
      wr(ADDR_SWITCH_CFG, 8'h01);
      dc_ok = 1'b0;
      waitc(SW - 2);
      `CHK("dc_wait", 1'b1, internal_supply_rail)
      waitc(4);
      `CHK("dc_switch", 1'b0, internal_supply_rail)
      rdchk(ADDR_EVENT_FLAGS, 8'h03, "flag_dc_low");
      waitc(RS + 4);
      `CHK("dc_hold", 1'b0, internal_supply_rail)
      dc_ok = 1'b1;
      waitc(RS + 4);
      `CHK("dc_back", 1'b1, internal_supply_rail)
      wr(ADDR_SWITCH_CFG, 8'h00);
      wr(ADDR_PIN_CFG, 8'h04);
      pin = 1'b0;
      waitc(2);
      `CHK("pin_switch", 1'b0, internal_supply_rail)
      waitc(RS + 4);
      `CHK("pin_hold", 1'b0, internal_supply_rail)
      pin = 1'b1;
      waitc(RS + 4);
      `CHK("pin_back", 1'b1, internal_supply_rail)
      wr(ADDR_SWITCH_CFG, 8'h02);
      vdd_ok = 1'b0;
      waitc(3);
      `CHK("switch_off", 1'b1, internal_supply_rail)
      vdd_ok = 1'b1;
      wr(ADDR_SWITCH_CFG, 8'h00);
      wr(ADDR_EVENT_FLAGS, 8'h00);
      bd = 8'h20;
      bv = 1'b1;
      waitc(1);
      bv = 1'b0;
      waitc(1);
      rdchk(ADDR_EVENT_FLAGS, 8'h04, "flag_battery");
      rdchk(ADDR_BAT_RESULT, 8'h20, "bat_result");
      wr(ADDR_DELTA, 8'h10);
      dd = 8'h11;
      dv = 1'b1;
      waitc(1);
      dv = 1'b0;
      waitc(1);
      rdchk(ADDR_EVENT_FLAGS, 8'h0C, "flag_delta");
      wr(ADDR_EVENT_FLAGS, 8'h00);
      dd = 8'h18;
      dv = 1'b1;
      waitc(1);
      dv = 1'b0;
      waitc(1);
      rdchk(ADDR_EVENT_FLAGS, 8'h00, "small_delta");
      s0 = n_start;
      wr(ADDR_START_MEAS, 8'h01);
      `CHK("start_pulse", 1'b1, n_start > s0)
      dd = 8'h19;
      dv = 1'b1;
      waitc(1);
      dv = 1'b0;
      waitc(1);
      rdchk(ADDR_EVENT_FLAGS, 8'h08, "flag_started");
      wr(ADDR_BAT_THRESH, 8'h30);
      rdchk(ADDR_EVENT_FLAGS, 8'h0C, "flag_bat_low");
      wr(ADDR_EVENT_FLAGS, 8'h00);
      lbs = 1'b1;
      pulse_line();
      pulse_line();
      rdchk(ADDR_EVENT_FLAGS, 8'h00, "sag_early");
      pulse_line();
      waitc(1);
      rdchk(ADDR_EVENT_FLAGS, 8'h20, "flag_sag");
      `CHK("irq_sag", 1'b1, power_irq)
      tally_and_finish();
   end
endmodule // power_mgmt_tb
